// ### ocsf_pkg.sv
package ocsf_pkg;
  localparam int unsigned OCSF_MAX_BRIDGES = 12;
  localparam int unsigned OCSF_FLAG_W = 2 * OCSF_MAX_BRIDGES;
  localparam int unsigned OCSF_ADDR_W = 8;
  localparam int unsigned OCSF_DATA_W = 8;
  localparam int unsigned OCSF_BRIDGES_PER_REG = 4;

  localparam logic [OCSF_ADDR_W-1:0] OCSF_OFS_SUMMARY = 8'h00;
  localparam logic [OCSF_ADDR_W-1:0] OCSF_OFS_FLAGS_1_TO_4 = 8'h01;
  localparam logic [OCSF_ADDR_W-1:0] OCSF_OFS_FLAGS_5_TO_8 = 8'h02;
  localparam logic [OCSF_ADDR_W-1:0] OCSF_OFS_FLAGS_9_TO_12 = 8'h03;

  localparam int unsigned OCSF_SUMMARY_OC_BIT = 3;
  localparam int unsigned OCSF_LOW_SIDE_POS = 0;
  localparam int unsigned OCSF_HIGH_SIDE_POS = 1;

  localparam logic [OCSF_DATA_W-1:0] OCSF_RST_REG = 8'h00;
  localparam logic [OCSF_FLAG_W-1:0] OCSF_RST_FLAGS = 24'h00_0000;
  localparam logic [OCSF_DATA_W-1:0] OCSF_UNMAPPED_READ = 8'h00;

  typedef logic [OCSF_FLAG_W-1:0] ocsf_flags_t;
  typedef logic [OCSF_DATA_W-1:0] ocsf_byte_t;
endpackage

// ### ocsf_flag_if.sv
`timescale 1ns/1ps
interface ocsf_flag_if;
  import ocsf_pkg::*;
  ocsf_flags_t set_req;
  logic clear_all;
  ocsf_flags_t flags;

  modport ctrl (
    output set_req,
    output clear_all,
    input flags
  );

  modport bank (
    input set_req,
    input clear_all,
    output flags
  );
endinterface

// ### ocsf_flag_bank.sv
`timescale 1ns/1ps
module ocsf_flag_bank (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  ocsf_flag_if.bank fb // Set, clear and flag view
);
  import ocsf_pkg::*;

  ocsf_flags_t flags_q;
  ocsf_flags_t flags_d;

  // Set ORed after the clear, so a hit in the clear cycle survives
  always_comb begin
    flags_d = flags_q;
    if (fb.clear_all) begin
      flags_d = OCSF_RST_FLAGS; // (RULE8)
    end
    flags_d = flags_d | fb.set_req; // (RULE8)
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= OCSF_RST_FLAGS; // (RULE6)
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fb.flags = flags_q;
endmodule

// ### ocsf_top.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) Bridges 1-4 packed into register 0x01
// (RULE2) Bridges 5-8 packed into register 0x02
// (RULE3) Bridges 9-12 packed into register 0x03
// (RULE4) Flag one means overcurrent seen, else zero
// (RULE5) Host writes never change any flag
// (RULE6) All flags zero after reset
// (RULE7) Summary register bit 3 ORs all flags
// (RULE8) Flags latch until fault clear or reset
module ocsf_top #(
  parameter int unsigned NUM_BRIDGES = ocsf_pkg::OCSF_MAX_BRIDGES
) (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [ocsf_pkg::OCSF_MAX_BRIDGES-1:0] oc_high_det, // Detectors
  input wire logic [ocsf_pkg::OCSF_MAX_BRIDGES-1:0] oc_low_det, // Detectors
  input wire logic fault_clear_command, // One-cycle clear pulse
  input wire logic reg_rd, // Register read strobe
  input wire logic reg_wr, // Register write strobe
  input wire logic [ocsf_pkg::OCSF_ADDR_W-1:0] reg_addr, // Register offset
  input wire logic [ocsf_pkg::OCSF_DATA_W-1:0] reg_wdata, // Write data
  output logic [ocsf_pkg::OCSF_DATA_W-1:0] reg_rdata, // Read data
  output logic reg_ack, // Access done pulse
  output logic reg_hit, // Access hit a mapped offset
  output logic oc_any, // Any flag set
  output logic [ocsf_pkg::OCSF_FLAG_W-1:0] oc_flags // Latched flags
);
  import ocsf_pkg::*;

  // Interleave high/low detectors: low on even bit, high on odd bit
  function automatic ocsf_flags_t pack_sides(
    input logic [OCSF_MAX_BRIDGES-1:0] hi,
    input logic [OCSF_MAX_BRIDGES-1:0] lo
  );
    ocsf_flags_t v;
    v = OCSF_RST_FLAGS;
    for (int i = 0; i < OCSF_MAX_BRIDGES; i++) begin
      v[2*i+OCSF_LOW_SIDE_POS] = lo[i]; // (RULE1)
      v[2*i+OCSF_HIGH_SIDE_POS] = hi[i]; // (RULE1)
    end
    return v;
  endfunction

  // Byte n of the flag vector holds four consecutive bridges
  function automatic ocsf_byte_t flag_byte(
    input ocsf_flags_t f,
    input int unsigned idx
  );
    ocsf_byte_t b;
    b = OCSF_RST_REG;
    for (int j = 0; j < OCSF_DATA_W; j++) begin
      b[j] = f[idx*OCSF_DATA_W+j];
    end
    return b;
  endfunction

  // One offset decode feeds the read mux and the hit flag alike
  typedef enum logic [2:0] {
    OCSF_SEL_SUMMARY,
    OCSF_SEL_BRIDGES_1_TO_4,
    OCSF_SEL_BRIDGES_5_TO_8,
    OCSF_SEL_BRIDGES_9_TO_12,
    OCSF_SEL_NONE
  } ocsf_sel_t;

  function automatic ocsf_sel_t decode_offset(
    input logic [OCSF_ADDR_W-1:0] a
  );
    ocsf_sel_t s;
    s = OCSF_SEL_NONE;
    if (a == OCSF_OFS_SUMMARY) begin
      s = OCSF_SEL_SUMMARY; // (RULE7)
    end else if (a == OCSF_OFS_FLAGS_1_TO_4) begin
      s = OCSF_SEL_BRIDGES_1_TO_4; // (RULE1)
    end else if (a == OCSF_OFS_FLAGS_5_TO_8) begin
      s = OCSF_SEL_BRIDGES_5_TO_8; // (RULE2)
    end else if (a == OCSF_OFS_FLAGS_9_TO_12) begin
      s = OCSF_SEL_BRIDGES_9_TO_12; // (RULE3)
    end
    return s;
  endfunction

  function automatic logic is_mapped(input logic [OCSF_ADDR_W-1:0] a);
    return decode_offset(a) != OCSF_SEL_NONE;
  endfunction

  // Bridges beyond the fitted count never report
  function automatic ocsf_flags_t fitted_mask(input int unsigned n);
    ocsf_flags_t m;
    m = OCSF_RST_FLAGS;
    for (int i = 0; i < OCSF_MAX_BRIDGES; i++) begin
      if (i < n) begin
        m[2*i+OCSF_LOW_SIDE_POS] = 1'b1;
        m[2*i+OCSF_HIGH_SIDE_POS] = 1'b1;
      end
    end
    return m;
  endfunction

  localparam ocsf_flags_t FITTED = fitted_mask(NUM_BRIDGES);

  ocsf_flag_if fb ();

  // Detectors are analog-side levels, so two stages before use
  // A pulse shorter than one clock period can slip past
  ocsf_flags_t det_meta_q;
  ocsf_flags_t det_sync_q;
  ocsf_flags_t det_raw;

  assign det_raw = pack_sides(oc_high_det, oc_low_det);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_meta_q <= OCSF_RST_FLAGS;
      det_sync_q <= OCSF_RST_FLAGS;
    end else begin
      det_meta_q <= det_raw;
      det_sync_q <= det_meta_q;
    end
  end

  // Level assertion latches, so a short pulse is not missed after sync
  assign fb.set_req = det_sync_q & FITTED; // (RULE4) (RULE8)
  assign fb.clear_all = fault_clear_command; // (RULE8)

  // Set wins over clear when both land in one cycle
  ocsf_flag_bank u_bank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fb(fb)
  );

  ocsf_byte_t summary_val;
  ocsf_byte_t rdata_d;
  ocsf_byte_t rdata_q;
  logic ack_q;
  logic hit_q;
  logic any_q;
  ocsf_flags_t flags_out_q;
  ocsf_sel_t reg_sel;
  logic access;
  logic flags_any;

  assign reg_sel = decode_offset(reg_addr);
  assign access = reg_rd | reg_wr;
  // Shared by the summary byte and the any output
  assign flags_any = |fb.flags; // (RULE7)

  // Only the overcurrent bit lives here; other summary bits stay zero
  always_comb begin
    summary_val = OCSF_RST_REG;
    summary_val[OCSF_SUMMARY_OC_BIT] = flags_any; // (RULE7)
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = OCSF_UNMAPPED_READ;
    unique case (reg_sel)
      OCSF_SEL_SUMMARY: rdata_d = summary_val; // (RULE7)
      OCSF_SEL_BRIDGES_1_TO_4: rdata_d = flag_byte(fb.flags, 0); // (RULE1)
      OCSF_SEL_BRIDGES_5_TO_8: rdata_d = flag_byte(fb.flags, 1); // (RULE2)
      OCSF_SEL_BRIDGES_9_TO_12: rdata_d = flag_byte(fb.flags, 2); // (RULE3)
      OCSF_SEL_NONE: rdata_d = OCSF_UNMAPPED_READ;
    endcase
  end

  // Read data holds until the next read
  // Writes never load it, so a flag cannot be written over
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= OCSF_RST_REG; // (RULE6)
    end else if (reg_rd) begin
      rdata_q <= rdata_d; // (RULE4)
    end
  end

  // Writes are acknowledged but the data goes nowhere
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access; // (RULE5)
    end
  end

  // Hit marks a mapped offset for reads and writes alike
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= access & is_mapped(reg_addr);
    end
  end

  // Registered copies trail the bank by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      any_q <= 1'b0; // (RULE6)
    end else begin
      any_q <= flags_any; // (RULE7)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_out_q <= OCSF_RST_FLAGS; // (RULE6)
    end else begin
      flags_out_q <= fb.flags; // (RULE4)
    end
  end

  // Write data is deliberately unused: every register here is read-only
  logic unused_wdata;
  assign unused_wdata = ^reg_wdata; // (RULE5)

  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign reg_hit = hit_q;
  assign oc_any = any_q;
  assign oc_flags = flags_out_q;
endmodule

// ### ocsf_host.sv
`timescale 1ns/1ps
module ocsf_host (
  input wire logic ref_clk, // Clock
  output ocsf_pkg::ocsf_byte_t reg_addr, // Offset
  output ocsf_pkg::ocsf_byte_t reg_wdata, // Write data
  output logic reg_rd, // Read strobe
  output logic reg_wr // Write strobe
);
  initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h0_0000;
  // Released bus shows the inverted offset and random write data, not the last offset
  task automatic acc(input logic w, input ocsf_pkg::ocsf_byte_t a);
    @(negedge ref_clk);
    {reg_rd, reg_wr, reg_addr, reg_wdata} <= {!w, w, a, 8'($urandom)};
    @(negedge ref_clk);
    {reg_rd, reg_wr, reg_addr, reg_wdata} <= {2'h0, ~a, 8'($urandom)};
  endtask
endmodule

// ### ocsf_top_sva.sv
`timescale 1ns/1ps
module ocsf_top_sva (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [11:0] oc_low_det, // Detect
  input wire logic fault_clear_command, // Clear
  input wire logic reg_rd, // Read
  input wire logic reg_wr, // Write
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [7:0] reg_rdata, // Data
  input wire logic oc_any, // Any
  input wire logic [23:0] oc_flags // Flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  map_lo_a: assert property (
    reg_rd && reg_addr == 8'h01 |=> reg_rdata == oc_flags[7:0])
    else $error("Bad 0x01");
  map_mid_a: assert property (
    reg_rd && reg_addr == 8'h02 |=> reg_rdata == oc_flags[15:8])
    else $error("Bad 0x02");
  map_hi_a: assert property (
    reg_rd && reg_addr == 8'h03 |=> reg_rdata == oc_flags[23:16])
    else $error("Bad 0x03");
  any_flag_a: assert property (oc_any == |oc_flags)
    else $error("Bad any");
  wr_keeps_a: assert property (
    reg_wr && !reg_rd |=> $stable(reg_rdata)) else $error("Write hit data");
  flag_hold_a: assert property (
    |($past(oc_flags) & ~oc_flags) |-> $past(fault_clear_command, 2))
    else $error("Flag fell");
  flag_set_a: assert property (
    $rose(oc_flags[0]) |-> $past(oc_low_det[0], 4)) else $error("Bad set");
  rst_zero_a: assert property (disable iff (1'b0)
    !rst_n |-> oc_flags == 24'h00_0000 && !oc_any) else $error("Bad reset");
endmodule
bind ocsf_top ocsf_top_sva u_sva (.ref_clk, .rst_n, .oc_low_det,
  .fault_clear_command, .reg_rd, .reg_wr, .reg_addr, .reg_rdata, .oc_any,
  .oc_flags);

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import ocsf_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b1;
  logic clr = 1'b0;
  logic [11:0] hi = 12'h000;
  logic [11:0] lo = 12'h000;
  logic reg_rd, reg_wr, reg_ack, reg_hit, oc_any;
  ocsf_byte_t reg_addr, reg_wdata, reg_rdata;
  ocsf_byte_t last = 8'h00;
  ocsf_flags_t oc_flags;
  ocsf_flags_t exp_f = 24'h00_0000;
  logic [8:0] q[$];
  logic [24:0] fq[$];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  ocsf_host host (.ref_clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata);
  ocsf_top dut (.ref_clk, .rst_n, .oc_high_det(hi), .oc_low_det(lo),
    .fault_clear_command(clr), .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ack, .reg_hit, .oc_any, .oc_flags);
  task automatic chk(input logic [8:0] got, input logic [8:0] want);
    samples_checked++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_flags(input logic [24:0] got, input logic [24:0] want);
    samples_checked++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH %0t flags got %h want %h", $time, got, want);
    end
  endtask
  always @(negedge ref_clk) begin
    if (reg_ack === 1'b1) begin
      chk({reg_hit, reg_rdata}, q.pop_front());
      chk_flags({oc_any, oc_flags}, fq.pop_front());
    end
  end
  // Writes expect the last read data to stand
  task automatic acc(input logic w, input ocsf_byte_t a);
    if (!w) last = a == 8'h00 ? {4'h0, |exp_f, 3'h0} :
      a < 8'h04 ? exp_f[8*(int'(a)-1) +: 8] : 8'h00;
    q.push_back({a < 8'h04, last});
    fq.push_back({|exp_f, exp_f});
    host.acc(w, a);
  endtask
  task automatic rd_all();
    for (int a = 0; a < 5; a++) acc(1'b0, 8'(a));
    acc(1'b0, 8'hff);
  endtask
  task automatic det(input ocsf_flags_t p);
    @(negedge ref_clk);
    for (int j = 0; j < 12; j++) {hi[j], lo[j]} = p[2*j +: 2];
    exp_f = exp_f | p;
    repeat (2) @(negedge ref_clk);
    {hi, lo} = 24'h00_0000;
    repeat (4) @(negedge ref_clk);
  endtask
  initial begin
    // A real falling edge at time zero, so no flop starts unknown
    rst_n <= 1'b0;
    void'($urandom(3));
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    rd_all();
    for (int i = 0; i < 30; i++) begin
      det(i < 24 ? 24'h00_0001 << i : 24'($urandom));
      rd_all();
      acc(1'b1, 8'(1 + i % 3));
      acc(1'b0, 8'(1 + i % 3));
      if (i % 2) begin
        @(negedge ref_clk) clr = 1'b1;
        @(negedge ref_clk) clr = 1'b0;
        exp_f = 24'h00_0000;
      end
    end
    // Synced detector still high at the clear edge: the set wins
    @(negedge ref_clk) lo[0] = 1'b1;
    exp_f = 24'h00_0001;
    repeat (3) @(negedge ref_clk);
    lo[0] = 1'b0;
    @(negedge ref_clk) clr = 1'b1;
    @(negedge ref_clk) clr = 1'b0;
    acc(1'b0, 8'h01);
    repeat (2) @(negedge ref_clk);
    if (q.size() != 0 || fq.size() != 0) begin
      n_fail++;
      $display("MISMATCH %0t %0d answers missing", $time, q.size());
    end
    summarize();
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule
